//--- core/ipa_pkg.sv
// Package of constants and types for the interrupt priority arbiter
package ipa_pkg;
    localparam int NUM_VEC = 14;
    localparam int NUM_LVL = 4;
    localparam int PRIO_W = 2;
    localparam int VEC_W = 4;
    localparam int NMI_PRIO = 4;
    localparam logic [VEC_W-1:0] VEC_RESET = 4'h0;
    localparam logic [3:0] SRC_PER_VEC = 4'h6;
    // Vector numbers of the shared vectors, by polling level
    localparam int VEC_TMR2_GRP = 6;
    localparam int VEC_EXT2_GRP = 9;
    localparam int VEC_EXT3_GRP = 10;
    localparam int VEC_CCU_NP0 = 11;
    typedef enum logic [1:0] {
        IPA_IDLE = 2'b00,
        IPA_GRANT = 2'b01,
        IPA_WAIT = 2'b11
    } ipa_state_t;
endpackage

//--- core/ipa_src_merge.sv
// Merges several request sources onto one vector and reports which fired
`timescale 1ns/100ps
`default_nettype none
module ipa_src_merge #(
    parameter int NSRC = 6
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Sources
    input wire logic [NSRC-1:0] src_in,
    // Merged vector request and source flags
    output logic req_out,
    output logic [NSRC-1:0] flags_out
);
    logic [NSRC-1:0] next_flags;

    // Collect source flags so software can tell who requested; all clear once no source is active
    always_comb
    begin
        next_flags = flags_out | src_in;
        if (src_in == '0)
        begin
            next_flags = flags_out & src_in;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            flags_out <= '0;
        end
        else
        begin
            flags_out <= next_flags;
        end
    end

    // Vector request is the OR of its sources
    assign req_out = |src_in;
endmodule
`default_nettype wire

//--- core/ipa_arbiter.sv
// Interrupt priority arbiter: one non-maskable and fourteen maskable vectors
// How it works
// RULE1 - One non-maskable request and fourteen maskable vectors go to the core.
// RULE2 - Each vector has its own priority and mask, and shared vectors keep source flags; vectors 11-14 have none and flags clear once no source is active.
// RULE3 - A running service is preempted only by a strictly higher priority request.
// RULE4 - Among simultaneous requests the highest priority level wins.
// RULE5 - Ties at one level are broken by polling order, non-maskable first then 1 to 14.
// RULE6 - Vector 6 merges timer 2, the uart divider overflow, the can unit and lin.
// RULE7 - Vector 9 merges six sources and vector 10 merges external 3..6 and can.
// RULE8 - Vectors 11 to 14 each serve one capture compare node pointer plus can.
// RULE9 - Masked requests drop out, arbitration runs every cycle, grant waits for a boundary.
`timescale 1ns/100ps
`default_nettype none
module ipa_arbiter #(
    parameter int NVEC = ipa_pkg::NUM_VEC,
    parameter int NSRC = 6
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Request sources; vectors 1..14 are bits 0..13
    input wire logic nmi_req_in,
    input wire logic [NVEC-1:0] vec_req_in,
    input wire logic [NSRC-1:0] tmr2_grp_src_in,
    input wire logic [NSRC-1:0] ext2_grp_src_in,
    input wire logic [NSRC-1:0] ext3_grp_src_in,
    input wire logic [4*2-1:0] ccu_np_src_in,
    // Configuration
    input wire logic global_en_in,
    input wire logic [NVEC-1:0] vec_en_in,
    input wire logic [2*NVEC-1:0] vec_prio_in,
    // Core handshake
    input wire logic instr_boundary_in,
    input wire logic reti_in,
    // Grant to the core
    output logic irq_valid_out,
    output logic [ipa_pkg::VEC_W-1:0] irq_vec_out,
    output logic irq_nmi_out,
    output logic [ipa_pkg::PRIO_W:0] active_prio_out,
    // Source status
    output logic [NSRC-1:0] tmr2_grp_flags_out,
    output logic [NSRC-1:0] ext2_grp_flags_out,
    output logic [NSRC-1:0] ext3_grp_flags_out
);
    localparam int LW = ipa_pkg::PRIO_W + 1;

    logic [NVEC-1:0] req;
    logic [NVEC-1:0] eff;
    logic m6, m9, m10;
    logic [3:0] ccu_req;
    logic win_found;
    logic [ipa_pkg::VEC_W-1:0] win_vec;
    logic [LW-1:0] win_lvl;
    logic win_nmi;
    logic [LW-1:0] stack_top;
    logic [3:0] depth;
    logic [3:0] next_depth;
    logic [LW-1:0] stack [0:4];
    logic [LW-1:0] next_stack [0:4];
    logic next_valid, next_nmi;
    logic [ipa_pkg::VEC_W-1:0] next_vec;

    // Shared vectors merged from their sources [RULE2] [RULE6] [RULE7]
    ipa_src_merge #(.NSRC(NSRC)) u_m6 (
        .mclk_in(mclk_in), .resetn_in(resetn_in),
        .src_in(tmr2_grp_src_in), .req_out(m6), .flags_out(tmr2_grp_flags_out));
    ipa_src_merge #(.NSRC(NSRC)) u_m9 (
        .mclk_in(mclk_in), .resetn_in(resetn_in),
        .src_in(ext2_grp_src_in), .req_out(m9), .flags_out(ext2_grp_flags_out));
    ipa_src_merge #(.NSRC(NSRC)) u_m10 (
        .mclk_in(mclk_in), .resetn_in(resetn_in),
        .src_in(ext3_grp_src_in), .req_out(m10), .flags_out(ext3_grp_flags_out));

    // Node pointer pairs: node request or its can request [RULE8]
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ccu
            assign ccu_req[g] = |ccu_np_src_in[2*g +: 2];
        end
    endgenerate

    // Vector requests; shared vectors OR their merged value into their own request
    always_comb
    begin
        req = vec_req_in;
        req[ipa_pkg::VEC_TMR2_GRP-1] = vec_req_in[ipa_pkg::VEC_TMR2_GRP-1] | m6;
        req[ipa_pkg::VEC_EXT2_GRP-1] = vec_req_in[ipa_pkg::VEC_EXT2_GRP-1] | m9;
        req[ipa_pkg::VEC_EXT3_GRP-1] = vec_req_in[ipa_pkg::VEC_EXT3_GRP-1] | m10;
        for (int k = 0; k < 4; k++)
        begin
            req[ipa_pkg::VEC_CCU_NP0-1+k] = vec_req_in[ipa_pkg::VEC_CCU_NP0-1+k] | ccu_req[k];
        end
        eff = req & vec_en_in & {NVEC{global_en_in}}; // [RULE9]
    end

    // Level of a vector, one above the configured priority
    function automatic logic [LW-1:0] lvl_of(input logic [2*NVEC-1:0] p, input int v);
        lvl_of = {1'b0, p[2*v +: 2]} + 3'd1;
    endfunction

    // Highest level wins, lowest poll number on a tie [RULE4] [RULE5]
    always_comb
    begin
        win_found = 1'b0;
        win_vec = ipa_pkg::VEC_RESET;
        win_lvl = '0;
        win_nmi = 1'b0;
        if (nmi_req_in)
        begin
            win_found = 1'b1;
            win_nmi = 1'b1;
            win_lvl = LW'(ipa_pkg::NMI_PRIO);
        end
        else
        begin
            for (int v = 0; v < NVEC; v++)
            begin
                if (eff[v] && (!win_found || lvl_of(vec_prio_in, v) > win_lvl))
                begin
                    win_found = 1'b1;
                    win_vec = ipa_pkg::VEC_W'(v + 1);
                    win_lvl = lvl_of(vec_prio_in, v);
                end
            end
        end
    end

    assign stack_top = stack[depth[2:0]];

    // Grant at a boundary only when strictly above the running level
    always_comb
    begin
        next_depth = depth;
        next_valid = 1'b0;
        next_vec = irq_vec_out;
        next_nmi = irq_nmi_out;
        for (int i = 0; i < 5; i++)
        begin
            next_stack[i] = stack[i];
        end
        if (reti_in && depth != 4'h0)
        begin
            next_depth = depth - 4'h1;
        end
        else if (instr_boundary_in && win_found && win_lvl > stack_top && depth < 4'h4) // [RULE3] [RULE9]
        begin
            next_depth = depth + 4'h1;
            next_stack[depth[2:0] + 3'd1] = win_lvl;
            next_valid = 1'b1;
            next_vec = win_vec;
            next_nmi = win_nmi;
        end
    end

    // Service stack and grant registers
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            depth <= 4'h0;
            irq_valid_out <= 1'b0;
            irq_vec_out <= ipa_pkg::VEC_RESET;
            irq_nmi_out <= 1'b0;
            for (int i = 0; i < 5; i++)
            begin
                stack[i] <= '0;
            end
        end
        else
        begin
            depth <= next_depth;
            irq_valid_out <= next_valid;
            irq_vec_out <= next_vec;
            irq_nmi_out <= next_nmi; // [RULE1]
            for (int i = 0; i < 5; i++)
            begin
                stack[i] <= next_stack[i];
            end
        end
    end

    assign active_prio_out = stack_top;

    // Steps of a grant: a winner above the running level at a boundary, then the pulse
    sequence s_taken;
        instr_boundary_in && !reti_in && win_found && win_lvl > stack_top && depth < 4'h4;
    endsequence
    sequence s_shown;
        irq_valid_out && active_prio_out == $past(win_lvl);
    endsequence

    // A taken request is shown on the next cycle at its level
    a_grant_follows: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE9]
        s_taken |=> s_shown) else $error("grant not shown");
    // No grant unless it beats the running level
    a_no_equal_preempt: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE3]
        irq_valid_out |-> active_prio_out > $past(active_prio_out))
        else $error("equal level preempted");
    // Masked vectors never granted; enables are looked up at the granted vector
    a_mask_blocks: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE9]
        irq_valid_out && !irq_nmi_out |->
        $past(global_en_in) && |($past(vec_en_in) & (NVEC'(1) << (irq_vec_out - 4'h1))))
        else $error("masked vector granted");
    // Non-maskable request wins
    a_nmi_first: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE5]
        next_valid && nmi_req_in |=> irq_nmi_out) else $error("nmi lost");
    // Grant only at boundary
    a_grant_boundary: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE9]
        irq_valid_out |-> $past(instr_boundary_in)) else $error("grant off boundary");
    // Grant raises the stack depth by one frame
    a_depth_step: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE4]
        irq_valid_out |-> depth == $past(depth) + 4'h1) else $error("depth wrong");
    // A return ends one service level and blocks a grant in that cycle
    a_reti_pop: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE3]
        reti_in && depth != 4'h0 |=> depth == $past(depth) - 4'h1 && !irq_valid_out)
        else $error("return did not pop");
    // Shared vectors react to their sources
    a_share_six: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE6]
        |tmr2_grp_src_in |-> req[5]) else $error("vector 6 missed");
    a_share_nine: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE7]
        |ext2_grp_src_in |-> req[8] && req[9] == (vec_req_in[9] | m10))
        else $error("vector 9 missed");
    a_share_ccu: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE8]
        ccu_np_src_in[0] |-> req[10]) else $error("vector 11 missed");
    // Source flag is set on the cycle after its source fires
    a_flags_kept: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [RULE2]
        tmr2_grp_src_in[0] |=> tmr2_grp_flags_out[0]) else $error("flag lost");
endmodule
`default_nettype wire

//--- sim/ipa_core_model.sv
// Behavioural core model: takes grants and returns from service after a delay
`timescale 1ns/100ps
`default_nettype none
module ipa_core_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Grant and bench controls
    input wire logic valid_in,
    input wire logic hold_in,
    input wire logic [3:0] dly_in,
    // Core handshake
    output logic bnd_out,
    output logic reti_out
);
    logic [2:0] depth;
    logic [3:0] cnt;
    // No boundary in the fetch cycle after a grant; one return per taken grant
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            {depth, cnt, reti_out, bnd_out} <= '0;
        else
        begin
            bnd_out <= !valid_in;
            reti_out <= 1'b0;
            if (valid_in)
                {depth, cnt} <= {depth + 3'h1, dly_in};
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (depth != 3'h0 && !hold_in && !reti_out)
                {depth, reti_out} <= {depth - 3'h1, 1'b1};
        end
    end
endmodule
`default_nettype wire

//--- sim/test_interrupt_priority_arbiter.sv
// Self-checking bench for the interrupt priority arbiter
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_priority_arbiter;
    logic mclk_in = 1'b0, resetn_in = 1'b0, nmi = 1'b0, gen = 1'b0, hold = 1'b0;
    logic [13:0] vq = '0, en = '0;
    logic [27:0] pr = '0;
    logic [5:0] t2 = '0, e2 = '0, e3 = '0, f2, f9, f10;
    logic [7:0] cc = '0, gv, gp, gf;
    logic [3:0] dly = 4'h2, vec;
    logic [2:0] act;
    logic bnd, reti, valid, vnmi, got;
    int n_fail = 0, checked = 0, ev, ep;
    // Clock at 200 MHz
    always #2.5 mclk_in = ~mclk_in;
    ipa_arbiter ipa_arbiter_inst (.mclk_in(mclk_in), .resetn_in(resetn_in), .nmi_req_in(nmi),
        .vec_req_in(vq), .tmr2_grp_src_in(t2), .ext2_grp_src_in(e2), .ext3_grp_src_in(e3),
        .ccu_np_src_in(cc), .global_en_in(gen), .vec_en_in(en), .vec_prio_in(pr),
        .instr_boundary_in(bnd), .reti_in(reti), .irq_valid_out(valid), .irq_vec_out(vec),
        .irq_nmi_out(vnmi), .active_prio_out(act), .tmr2_grp_flags_out(f2),
        .ext2_grp_flags_out(f9), .ext3_grp_flags_out(f10));
    ipa_core_model ipa_core_model_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .valid_in(valid), .hold_in(hold), .dly_in(dly), .bnd_out(bnd), .reti_out(reti));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Expected winner: NMI first, then highest enabled level, lower vector on ties
    function automatic int win(output int lvl);
        int b = -1;
        int bp = -1;
        for (int k = 0; k < 14; k++)
            if (gen && en[k] && vq[k] && int'(pr[2*k+:2]) > bp)
            begin
                b = k + 1;
                bp = int'(pr[2*k+:2]);
            end
        lvl = nmi ? 4 : bp + 1;
        return nmi ? 0 : b;
    endfunction
    // Wait up to 40 cycles for a grant, capture it, then drop all requests
    task automatic grant();
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++)
        begin
            @(posedge mclk_in);
            #1;
            got = (valid === 1'b1);
        end
        gv = vnmi ? 8'h80 : {4'h0, vec};
        gp = {5'h0, act};
        gf = {2'h0, f2 | f9 | f10};
        @(posedge mclk_in);
        {nmi, vq, t2, e2, e3, cc} <= '0;
    endtask
    // Wait, bounded, for the service stack to empty
    task automatic settle();
        int i = 0;
        do
        begin
            @(posedge mclk_in);
            #1;
            i++;
        end while (act !== 3'h0 && i < 200);
        if (act !== 3'h0)
        begin
            n_fail++;
            report_and_stop();
        end
        @(posedge mclk_in);
    endtask
    // Main sequence: sweep, random mixes, nesting, shared sources
    initial
    begin
        void'($urandom(33));
        repeat (20) @(posedge mclk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 74; i++)
        begin
            @(posedge mclk_in);
            dly <= 4'($urandom_range(1, 6));
            pr <= 28'($urandom);
            vq <= (i < 14) ? 14'h1 << i : 14'($urandom);
            en <= (i < 14) ? '1 : 14'($urandom | $urandom);
            gen <= (i < 14) || ($urandom_range(0, 3) != 0);
            nmi <= (i >= 14) && ($urandom_range(0, 7) == 0);
            #1; // Predict once the new inputs stand; the grant pulse follows the next edge
            ev = win(ep);
            grant();
            chk({7'h0, got}, {7'h0, ev >= 0});
            if (ev >= 0)
            begin
                chk(gv, (ev == 0) ? 8'h80 : 8'(ev));
                chk(gp, 8'(ep));
            end
            settle();
        end
        {gen, en, pr, hold, vq} <= {1'b1, 14'h3fff, 28'h20, 1'b1, 14'h1};
        grant();
        chk(gv, 8'h01);
        @(posedge mclk_in);
        vq <= 14'h2;
        grant();
        chk({7'h0, got}, 8'h00);
        @(posedge mclk_in);
        vq <= 14'h6;
        grant();
        chk(gv, 8'h03);
        chk(gp, 8'h03);
        @(posedge mclk_in);
        hold <= 1'b0;
        settle();
        for (int s = 0; s < 26; s++)
        begin
            t2 <= (s < 6) ? 6'h1 << s : '0;
            e2 <= (s >= 6 && s < 12) ? 6'h1 << (s - 6) : '0;
            e3 <= (s >= 12 && s < 18) ? 6'h1 << (s - 12) : '0;
            cc <= (s >= 18) ? 8'h1 << (s - 18) : '0;
            grant();
            chk(gv, (s < 6) ? 8'h06 : (s < 12) ? 8'h09 : (s < 18) ? 8'h0a : 8'(2 + s / 2));
            chk(gf, (s < 18) ? 8'h1 << (s % 6) : 8'h00);
            settle();
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
